// ---- logic/dpm_input_mux.sv ----
// Contract
// [RL1] Loop mode captures both ports each rise
// [RL2] Same rise outputs previous second-port word
// [RL3] Half period later outputs first-port word
// [RL4] Output instants independent of input duty cycle
// [RL5] Loop straps pick divide by 1/2/4/8
// [RL6] Loop supply low disables loop
// [RL7] Loop off: straps select input mode
// [RL8] Double-rate mode divides clock by two
// [RL9] Loop off: lock pin shows delayed phase
// [RL10] Double-rate mode updates output every edge
// [RL11] Source changes words on phase-rise edge
// [RL12] Source pulses divider reset before clocking
// [RL13] Reset forces phase high, low, high-load
// [RL14] Single-port loads selected latch on rise
// [RL15] Single-port output follows one rise later
// [RL16] Doubler mode sequences like loop mode
// [RL17] Source gives doubler 50% duty clock
// [RL18] Output codes are code and 4095-code
// [RL19] Loop mode: lock pin shows detector state
// [RL20] Ports are 12-bit straight binary words
// [RL21] Straps static, changed only with clock stopped; the testbench changes them under reset with the clock running
// [RL22] Unselected port never reaches output latch
module dpm_input_mux
    import dpm_pkg::*;
(
    // Clock and reset; each clock edge is an output update slot in interleaved modes, each phase rise in single-port modes
    input wire logic clk_sys,
    input wire logic arst_n,
    // Straps
    input wire logic loop_supply_strap,
    input wire logic range_select_high,
    input wire logic range_select_low,
    // Divider reset and loop detector
    input wire logic div_reset,
    input wire logic phase_detect_locked,
    // Input ports
    input wire logic [WORD_W-1:0] first_port_word,
    input wire logic [WORD_W-1:0] second_port_word,
    // Converter codes
    output logic [WORD_W-1:0] true_current_output,
    output logic [WORD_W-1:0] complement_current_output,
    // Clock status
    output logic lock_indicator,
    output logic input_phase,
    output logic [3:0] range_divide_ratio
);

    typedef struct packed {
        logic [WORD_W-1:0] first_latch;
        logic [WORD_W-1:0] second_latch;
        logic lock;
        logic [3:0] ratio;
    } dpm_mux_state_type;

    dpm_mux_state_type state;
    dpm_mux_state_type next_state;
    dpm_mode_type mode;
    logic [1:0] sel;
    logic loop_on;
    logic half_rate;
    logic half_rate_delayed;
    logic half_rate_rise;
    logic out_load;
    logic [WORD_W-1:0] out_word;

    ////////////////////////////////////////////////////////////////////////////////

    // Straps are taken as static; they are decoded live with no capture
    assign sel = {range_select_high, range_select_low}; // [RL5] [RL21]
    assign loop_on = loop_supply_strap; // [RL6]
    assign mode = dpm_decode_mode(loop_on, sel); // [RL7]

    dpm_phase_gen u_phase (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .div_reset(div_reset),
        .reset_enable(!loop_on), // [RL13]
        .half_rate(half_rate),
        .half_rate_delayed(half_rate_delayed),
        .half_rate_rise(half_rate_rise)
    );

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        next_state = state;
        out_load = 1'b0;
        out_word = state.second_latch;
        if (loop_on) begin
            next_state.lock = phase_detect_locked; // [RL19]
            next_state.ratio = dpm_range_ratio(sel); // [RL5]
        end else begin
            next_state.lock = half_rate_delayed; // [RL9]
            next_state.ratio = RATIO_RANGE_SELECT_HIGH;
        end
        case (mode)
            MODE_LOOP, MODE_DOUBLE_RATE, MODE_DOUBLER: begin
                // Slots come from the clock edges only, so duty cycle plays no part
                out_load = 1'b1; // [RL4] [RL10] [RL16]
                if (half_rate_rise) begin
                    next_state.first_latch = first_port_word; // [RL1]
                    next_state.second_latch = second_port_word; // [RL1] [RL11]
                    out_word = state.second_latch; // [RL2]
                end else begin
                    out_word = state.first_latch; // [RL3]
                end
            end
            MODE_FIRST_ONLY: begin
                if (half_rate_rise) begin
                    next_state.first_latch = first_port_word; // [RL14]
                    out_load = 1'b1; // [RL15]
                    out_word = state.first_latch; // [RL15] [RL22]
                end
            end
            MODE_SECOND_ONLY: begin
                if (half_rate_rise) begin
                    next_state.second_latch = second_port_word; // [RL14]
                    out_load = 1'b1; // [RL15]
                    out_word = state.second_latch; // [RL15] [RL22]
                end
            end
            default: begin
                out_load = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state.first_latch <= WORD_RESET;
            state.second_latch <= WORD_RESET;
            state.lock <= LOCK_RESET;
            state.ratio <= RATIO_RESET;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    dpm_output_latch u_out (
        .clk_sys(clk_sys),
        .arst_n(arst_n),
        .load(out_load),
        .load_word(out_word),
        .true_current_output(true_current_output),
        .complement_current_output(complement_current_output)
    );

    assign lock_indicator = state.lock;
    assign input_phase = half_rate;
    assign range_divide_ratio = state.ratio;

endmodule

// ---- logic/dpm_output_latch.sv ----
module dpm_output_latch
    import dpm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Load
    input wire logic load,
    input wire logic [WORD_W-1:0] load_word,
    // Steering codes
    output logic [WORD_W-1:0] true_current_output,
    output logic [WORD_W-1:0] complement_current_output
);

    typedef struct packed {
        logic [WORD_W-1:0] true_code;
        logic [WORD_W-1:0] comp_code;
    } dpm_out_state_type;

    dpm_out_state_type state;
    dpm_out_state_type next_state;

    always_comb begin
        next_state = state;
        if (load) begin
            // Code drives the true side, its complement the other
            next_state.true_code = load_word; // [RL18] [RL20]
            next_state.comp_code = FULL_CODE - load_word; // [RL18]
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state.true_code <= CODE_RESET;
            state.comp_code <= FULL_CODE;
        end else begin
            state <= next_state;
        end
    end

    assign true_current_output = state.true_code;
    assign complement_current_output = state.comp_code;

endmodule

// ---- logic/dpm_phase_gen.sv ----
module dpm_phase_gen
    import dpm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Control
    input wire logic div_reset,
    input wire logic reset_enable,
    // Phase
    output logic half_rate,
    output logic half_rate_delayed,
    output logic half_rate_rise
);

    typedef struct packed {
        logic phase;
        logic phase_delay;
    } dpm_phase_state_type;

    dpm_phase_state_type state;
    dpm_phase_state_type next_state;
    logic force_high;

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        force_high = div_reset && reset_enable;
        next_state = state;
        next_state.phase_delay = state.phase;
        if (force_high) begin
            next_state.phase = 1'b1; // [RL13]
        end else begin
            next_state.phase = ~state.phase; // [RL8] [RL13]
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            state.phase <= PHASE_RESET;
            state.phase_delay <= PHASE_RESET;
        end else begin
            state <= next_state;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////

    assign half_rate = state.phase;
    assign half_rate_delayed = state.phase_delay;
    // A forced-high phase is no rising edge, so with the loop off no port latch loads during a divider reset
    assign half_rate_rise = !state.phase && !force_high;

endmodule

// ---- logic/dpm_pkg.sv ----
package dpm_pkg;

    localparam int WORD_W = 12;
    localparam logic [WORD_W-1:0] FULL_CODE = 12'hfff;
    localparam logic [WORD_W-1:0] WORD_RESET = 12'h000;
    localparam logic [WORD_W-1:0] CODE_RESET = 12'h000;

    // Strap codes, range_select_high is bit 1
    localparam logic [1:0] SEL_DOUBLE_RATE = 2'h0;
    localparam logic [1:0] SEL_FIRST_ONLY = 2'h1;
    localparam logic [1:0] SEL_SECOND_ONLY = 2'h2;
    localparam logic [1:0] SEL_DOUBLER = 2'h3;

    // Range divider ratios with the loop active
    localparam logic [3:0] RATIO_RANGE_SELECT_HIGH = 4'h1;
    localparam logic [3:0] RATIO_DIV2 = 4'h2;
    localparam logic [3:0] RATIO_DIV4 = 4'h4;
    localparam logic [3:0] RATIO_DIV8 = 4'h8;
    localparam logic [3:0] RATIO_RESET = 4'h1;

    // Half-rate phase comes out of reset high, as after a divider reset
    localparam logic PHASE_RESET = 1'b1;
    localparam logic LOCK_RESET = 1'b0;

    typedef enum logic [2:0] {
        MODE_LOOP,
        MODE_DOUBLE_RATE,
        MODE_FIRST_ONLY,
        MODE_SECOND_ONLY,
        MODE_DOUBLER
    } dpm_mode_type;

    function automatic dpm_mode_type dpm_decode_mode(input logic loop_on,
                                                     input logic [1:0] sel);
        dpm_mode_type m;
        m = MODE_LOOP;
        if (!loop_on) begin
            case (sel)
                SEL_DOUBLE_RATE: m = MODE_DOUBLE_RATE;
                SEL_FIRST_ONLY: m = MODE_FIRST_ONLY;
                SEL_SECOND_ONLY: m = MODE_SECOND_ONLY;
                default: m = MODE_DOUBLER;
            endcase
        end
        return m;
    endfunction

    function automatic logic [3:0] dpm_range_ratio(input logic [1:0] sel);
        logic [3:0] r;
        r = RATIO_RANGE_SELECT_HIGH;
        case (sel)
            2'h0: r = RATIO_RANGE_SELECT_HIGH;
            2'h1: r = RATIO_DIV2;
            2'h2: r = RATIO_DIV4;
            default: r = RATIO_DIV8;
        endcase
        return r;
    endfunction

endpackage

// ---- test/dpm_input_mux_checker.sv ----
module dpm_input_mux_checker
    import dpm_pkg::*;
(
    // Clock, reset, straps
    input wire logic clk_sys,
    input wire logic arst_n,
    input wire logic loop_supply_strap,
    input wire logic range_select_high,
    input wire logic range_select_low,
    // Inputs
    input wire logic div_reset,
    input wire logic phase_detect_locked,
    input wire logic [WORD_W-1:0] first_port_word,
    input wire logic [WORD_W-1:0] second_port_word,
    // Outputs
    input wire logic [WORD_W-1:0] true_current_output,
    input wire logic [WORD_W-1:0] complement_current_output,
    input wire logic lock_indicator,
    input wire logic input_phase,
    input wire logic [3:0] range_divide_ratio
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);
    // Looks back three edges, so history must fill first
    logic [2:0] up;
    wire lp = loop_supply_strap;
    wire il = lp || (range_select_high == range_select_low);
    wire rise = (up == 3'h4) && !input_phase && (lp || !div_reset);
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            up <= 3'h0;
        end else if (up != 3'h4) begin
            up <= up + 3'h1;
        end
    end
    ////////////////////////////////////////////////////////////////
    a_code_compl: assert property (
        complement_current_output == FULL_CODE - true_current_output)
        else $error("complement code wrong");
    a_ratio_map: assert property (up == 3'h4 |-> range_divide_ratio ==
        (lp ? 4'h1 << {range_select_high, range_select_low} : RATIO_RANGE_SELECT_HIGH)) else $error("ratio wrong");
    a_loop_lock: assert property (
        lp && up == 3'h4 |-> lock_indicator == $past(phase_detect_locked))
        else $error("lock not detector");
    a_phase_lock: assert property (
        !lp && up == 3'h4 |-> lock_indicator == $past(input_phase, 2))
        else $error("lock not phase");
    a_phase_toggle: assert property (!lp && up == 3'h4 && !$past(div_reset) |->
        input_phase != $past(input_phase)) else $error("phase did not toggle");
    a_reset_force: assert property (!lp && div_reset |=> input_phase)
        else $error("phase not forced high");
    a_first_word: assert property (il && rise |=> ##1 true_current_output ==
        $past(first_port_word, 2)) else $error("first word slot wrong");
    a_second_word: assert property (il && rise && $past(rise, 2) |=>
        true_current_output == $past(second_port_word, 3)) else $error("second word slot wrong");
    a_single_word: assert property (!il && rise && $past(rise, 2) |=>
        true_current_output == (range_select_low ? $past(first_port_word, 3) :
        $past(second_port_word, 3))) else $error("single port word wrong");
    a_single_hold: assert property (!il && rise |=> ##1 $stable(true_current_output))
        else $error("single port output moved");
    c_loop: cover property (lp && rise);
    c_forced: cover property (!lp && div_reset ##1 !div_reset);
    c_single: cover property (!il && rise && $past(rise, 2));
endmodule

bind dpm_input_mux dpm_input_mux_checker i_dpm_input_mux_checker (.*);

// ---- test/dpm_source_model.sv ----
module dpm_source_model
    import dpm_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // Device phase
    input wire logic input_phase,
    // Source side
    output logic [WORD_W-1:0] first_port_word,
    output logic [WORD_W-1:0] second_port_word,
    output logic phase_detect_locked
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] r;
    initial begin
        first_port_word = WORD_RESET;
        second_port_word = WORD_RESET;
        phase_detect_locked = 1'b0;
    end
    // Words move just after a load edge and at each falling edge of a forced-high phase, so between loads they stand a full half-rate period
    always @(negedge clk_sys) begin
        r = $urandom;
        phase_detect_locked <= r[31];
        if (arst_n && input_phase) begin
            first_port_word <= (r[13:12] == 2'h0) ? FULL_CODE : r[11:0];
            second_port_word <= (r[15:14] == 2'h0) ? 12'h000 : r[27:16];
        end
    end
endmodule

// ---- test/testbench.sv ----
module testbench
    import dpm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic loop_supply_strap = 1'b0;
    logic range_select_high = 1'b0;
    logic range_select_low = 1'b0;
    logic div_reset = 1'b0;
    logic phase_detect_locked, lock_indicator, input_phase;
    logic [WORD_W-1:0] first_port_word, second_port_word;
    logic [WORD_W-1:0] true_current_output, complement_current_output;
    logic [3:0] range_divide_ratio;
    int num_errors = 0;
    int checks = 0;
    int cycles = 0;
    int cnt = 0;
    logic ph, pd, lk;
    logic [WORD_W-1:0] l1, l2, eout;
    wire il = loop_supply_strap || (range_select_high == range_select_low);
    always #20 clk_sys = ~clk_sys;
    dpm_input_mux i_dpm_input_mux (.*);
    dpm_source_model i_dpm_source_model (.*);
    ////////////////////////////////////////////////////////////////
    task automatic cmp_word(input logic [WORD_W-1:0] got, input logic [WORD_W-1:0] exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_flag(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            num_errors++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic final_report;
        $display("checks=%0d num_errors=%0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // Reference of the device, updated on the same edges as the design
    always @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            {ph, pd, lk} = {PHASE_RESET, PHASE_RESET, LOCK_RESET};
            {l1, l2, eout} = {WORD_RESET, WORD_RESET, CODE_RESET};
            cnt = 0;
        end else begin
            lk = loop_supply_strap ? phase_detect_locked : pd;
            pd = ph;
            cnt++;
            if (!loop_supply_strap && div_reset) begin
                // Interleaved output latch still runs on every edge while forced
                if (il) begin
                    eout = l1;
                end
                ph = 1'b1;
            end else begin
                if (!ph) begin
                    eout = (il || range_select_high) ? l2 : l1;
                    l1 = first_port_word;
                    l2 = second_port_word;
                end else if (il) begin
                    eout = l1;
                end
                ph = !ph;
            end
        end
    end
    always @(negedge clk_sys) begin
        if (arst_n && cnt > 0) begin
            cmp_word(true_current_output, eout);
            cmp_word(complement_current_output, FULL_CODE - eout);
            cmp_flag(input_phase, ph);
            cmp_word({8'h00, range_divide_ratio}, loop_supply_strap ?
                12'h001 << {range_select_high, range_select_low} : 12'h001);
            if (cnt > 2) begin
                cmp_flag(lock_indicator, lk);
            end
        end
    end
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 2000) begin
            num_errors++;
            final_report;
        end
    end
    initial begin
        void'($urandom(32'h34211698));
        for (int i = 0; i < 8; i++) begin
            @(negedge clk_sys);
            arst_n <= 1'b0;
            {loop_supply_strap, range_select_high, range_select_low} <= i[2:0];
            div_reset <= 1'b1;
            repeat (5) @(negedge clk_sys);
            arst_n <= 1'b1;
            repeat ($urandom_range(3, 1)) @(negedge clk_sys);
            div_reset <= 1'b0;
            repeat (30) @(negedge clk_sys);
            // Mid-run divider reset with live latches; ignored with the loop on
            div_reset <= 1'b1;
            @(negedge clk_sys);
            div_reset <= 1'b0;
            repeat (29) @(negedge clk_sys);
        end
        final_report;
    end
endmodule
